/* rtl/emi_defs.svh */
// Register offsets, bit positions and reset values of the MAC interrupt block
`ifndef EMI_DEFS_SVH
`define EMI_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define EMI_OFF_RAW 12'h000
`define EMI_OFF_MASKED 12'h004
`define EMI_OFF_ENABLE 12'h008
`define EMI_OFF_CLEAR 12'h00C
`define EMI_OFF_STATE 12'h010
`define EMI_OFF_CTRL 12'h014

// ==========================================================================
// Source bit positions
`define EMI_B_TX_DONE 0
`define EMI_B_TX_STOP 1
`define EMI_B_TX_NOBUF 2
`define EMI_B_JABBER 3
`define EMI_B_RX_OVF 4
`define EMI_B_TX_UNF 5
`define EMI_B_RX_DONE 6
`define EMI_B_RX_NOBUF 7
`define EMI_B_RX_STOP 8
`define EMI_B_RX_WDOG 9
`define EMI_B_EARLY_TX 10
`define EMI_B_BUS_ERR 13
`define EMI_B_EARLY_RX 14
`define EMI_B_ABN_SUM 15
`define EMI_B_NORM_SUM 16
`define EMI_B_PHY 24
`define EMI_B_TSTAMP 25

// Control register bits
`define EMI_C_JUMBO 0
`define EMI_C_MASKED_VIEW 1

// ==========================================================================
// Widths, limits and reset values
`define EMI_NSRC 26
`define EMI_SRC_RESET 26'h0000000
`define EMI_EN_RESET 26'h0000000
`define EMI_LEN_STD 14'h0800
`define EMI_LEN_JUMBO 14'h2800
`define EMI_ZERO32 32'h00000000

`endif

/* rtl/emi_pkg.sv */
// Types shared by the MAC interrupt block
package emi_pkg;
    typedef logic [25:0] emi_src_t;
    typedef enum logic [1:0] {
        EMI_RUN,
        EMI_SUSPEND,
        EMI_STOP
    } emi_proc_e;
endpackage

/* rtl/emi_irq.sv */
// MAC and DMA interrupt status, enable and summary logic with APB access
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "emi_defs.svh"

module emi_irq (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_done_ev,
    input wire logic rx_done_ev,
    input wire logic early_rx_ev,
    input wire logic early_tx_ev,
    input wire logic tx_underflow_ev,
    input wire logic rx_overflow_ev,
    input wire logic bus_error_ev,
    input wire logic [2:0] bus_error_cause,
    input wire logic rx_desc_host_owned,
    input wire logic tx_desc_host_owned,
    input wire logic rx_poll_demand,
    input wire logic tx_poll_demand,
    input wire logic rx_stop_req,
    input wire logic tx_stop_req,
    input wire logic rx_frame_end,
    input wire logic tx_frame_end,
    input wire logic [13:0] rx_frame_len,
    input wire logic [13:0] tx_frame_len,
    input wire logic phy_irq,
    input wire logic tstamp_irq,
    input wire logic timestamp_status_read,
    output logic irq_q,
    output logic dma_enable_q,
    output logic rx_suspend_q,
    output logic tx_suspend_q,
    output logic tx_abort_q
);

    // ======================================================================
    // State
    emi_pkg::emi_src_t src_q;
    emi_pkg::emi_src_t src_d;
    emi_pkg::emi_src_t en_q;
    emi_pkg::emi_src_t set_ev;
    emi_pkg::emi_src_t clr_mask;
    emi_pkg::emi_proc_e rx_st_q;
    emi_pkg::emi_proc_e tx_st_q;
    logic [1:0] ctrl_q;
    logic [2:0] err_cause_q;
    logic [2:0] phy_sync_q;
    logic [2:0] ts_sync_q;
    logic phy_lvl_q;
    logic ts_lvl_q;
    logic phy_rise;
    logic ts_rise;
    logic norm_sum;
    logic abn_sum;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic rx_wdog;
    logic jabber;
    logic rx_stop_entry;
    logic tx_stop_entry;

    // Limit of the frame length depends on jumbo mode
    function automatic logic over_limit(input logic [13:0] len, input logic jumbo);
        over_limit = jumbo ? (len > `EMI_LEN_JUMBO) : (len > `EMI_LEN_STD);
    endfunction

    // ======================================================================
    // APB decode: zero wait states, unmapped addresses answer with error
    assign addr_ok = (paddr == `EMI_OFF_RAW) || (paddr == `EMI_OFF_MASKED) ||
                     (paddr == `EMI_OFF_ENABLE) || (paddr == `EMI_OFF_CLEAR) ||
                     (paddr == `EMI_OFF_STATE) || (paddr == `EMI_OFF_CTRL);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;

    // ======================================================================
    // Pin inputs from the PHY and timestamp domains: three flops, the last two stages must agree
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            phy_sync_q <= 3'h0;
            ts_sync_q <= 3'h0;
            phy_lvl_q <= 1'b0;
            ts_lvl_q <= 1'b0;
        end else begin
            phy_sync_q <= {phy_sync_q[1:0], phy_irq};
            ts_sync_q <= {ts_sync_q[1:0], tstamp_irq};
            if (phy_sync_q[1] == phy_sync_q[2]) begin
                phy_lvl_q <= phy_sync_q[2];
            end
            if (ts_sync_q[1] == ts_sync_q[2]) begin
                ts_lvl_q <= ts_sync_q[2];
            end
        end
    end
    assign phy_rise = (phy_sync_q[1] == phy_sync_q[2]) && phy_sync_q[2] && !phy_lvl_q;
    assign ts_rise = (ts_sync_q[1] == ts_sync_q[2]) && ts_sync_q[2] && !ts_lvl_q;

    // ======================================================================
    // Event collection
    assign rx_wdog = rx_frame_end && over_limit(rx_frame_len, ctrl_q[`EMI_C_JUMBO]);
    assign jabber = tx_frame_end && over_limit(tx_frame_len, ctrl_q[`EMI_C_JUMBO]);
    assign rx_stop_entry = (rx_stop_req || bus_error_ev) && (rx_st_q != emi_pkg::EMI_STOP);
    assign tx_stop_entry = (tx_stop_req || bus_error_ev || jabber) &&
                           (tx_st_q != emi_pkg::EMI_STOP);

    always_comb begin
        set_ev = `EMI_SRC_RESET;
        set_ev[`EMI_B_TX_DONE] = tx_done_ev;
        set_ev[`EMI_B_RX_DONE] = rx_done_ev;
        set_ev[`EMI_B_EARLY_RX] = early_rx_ev;
        set_ev[`EMI_B_EARLY_TX] = early_tx_ev;
        set_ev[`EMI_B_TX_UNF] = tx_underflow_ev;
        set_ev[`EMI_B_RX_OVF] = rx_overflow_ev;
        set_ev[`EMI_B_BUS_ERR] = bus_error_ev;
        set_ev[`EMI_B_RX_WDOG] = rx_wdog;
        set_ev[`EMI_B_JABBER] = jabber;
        set_ev[`EMI_B_RX_NOBUF] = rx_desc_host_owned && (rx_st_q == emi_pkg::EMI_RUN);
        set_ev[`EMI_B_TX_NOBUF] = tx_desc_host_owned && (tx_st_q == emi_pkg::EMI_RUN);
        set_ev[`EMI_B_RX_STOP] = rx_stop_entry;
        set_ev[`EMI_B_TX_STOP] = tx_stop_entry;
        set_ev[`EMI_B_PHY] = phy_rise;
        set_ev[`EMI_B_TSTAMP] = ts_rise;
        set_ev[`EMI_B_NORM_SUM] = norm_sum;
        set_ev[`EMI_B_ABN_SUM] = abn_sum;
    end

    // Summaries come from masked constituents; they are latched like any source
    assign norm_sum = |(src_q & en_q & ((26'h1 << `EMI_B_TX_DONE) | (26'h1 << `EMI_B_RX_DONE) |
                     (26'h1 << `EMI_B_TX_NOBUF) | (26'h1 << `EMI_B_EARLY_RX)));
    assign abn_sum = |(src_q & en_q & ((26'h1 << `EMI_B_TX_STOP) | (26'h1 << `EMI_B_JABBER) |
                    (26'h1 << `EMI_B_RX_OVF) | (26'h1 << `EMI_B_TX_UNF) |
                    (26'h1 << `EMI_B_RX_NOBUF) | (26'h1 << `EMI_B_RX_STOP) |
                    (26'h1 << `EMI_B_RX_WDOG) | (26'h1 << `EMI_B_EARLY_TX) |
                    (26'h1 << `EMI_B_BUS_ERR)));

    // ======================================================================
    // Sticky flags: write-one-to-clear, set wins over clear
    always_comb begin
        clr_mask = `EMI_SRC_RESET;
        if (wr_en && paddr == `EMI_OFF_CLEAR) begin
            clr_mask = pwdata[`EMI_NSRC-1:0];
        end
        clr_mask[`EMI_B_TSTAMP] = clr_mask[`EMI_B_TSTAMP] || timestamp_status_read;
        src_d = (src_q & ~clr_mask) | set_ev;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            src_q <= `EMI_SRC_RESET;
        end else begin
            src_q <= src_d;
        end
    end

    // ======================================================================
    // Enable and control registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            en_q <= `EMI_EN_RESET;
            ctrl_q <= 2'h0;
        end else if (wr_en) begin
            if (paddr == `EMI_OFF_ENABLE) begin
                en_q <= pwdata[`EMI_NSRC-1:0];
            end
            if (paddr == `EMI_OFF_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
        end
    end

    // ======================================================================
    // DMA process states; stopped is left only through reset
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_st_q <= emi_pkg::EMI_RUN;
        end else begin
            case (rx_st_q)
                emi_pkg::EMI_RUN: begin
                    if (rx_stop_entry) begin
                        rx_st_q <= emi_pkg::EMI_STOP;
                    end else if (rx_desc_host_owned) begin
                        rx_st_q <= emi_pkg::EMI_SUSPEND;
                    end
                end
                emi_pkg::EMI_SUSPEND: begin
                    if (rx_stop_entry) begin
                        rx_st_q <= emi_pkg::EMI_STOP;
                    end else if (rx_poll_demand && !rx_desc_host_owned) begin
                        rx_st_q <= emi_pkg::EMI_RUN;
                    end
                end
                emi_pkg::EMI_STOP: rx_st_q <= emi_pkg::EMI_STOP;
                default: rx_st_q <= emi_pkg::EMI_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_st_q <= emi_pkg::EMI_RUN;
        end else begin
            case (tx_st_q)
                emi_pkg::EMI_RUN: begin
                    if (tx_stop_entry) begin
                        tx_st_q <= emi_pkg::EMI_STOP;
                    end else if (tx_desc_host_owned || tx_underflow_ev) begin
                        tx_st_q <= emi_pkg::EMI_SUSPEND;
                    end
                end
                emi_pkg::EMI_SUSPEND: begin
                    if (tx_stop_entry) begin
                        tx_st_q <= emi_pkg::EMI_STOP;
                    end else if (tx_poll_demand && !tx_desc_host_owned) begin
                        tx_st_q <= emi_pkg::EMI_RUN;
                    end
                end
                emi_pkg::EMI_STOP: tx_st_q <= emi_pkg::EMI_STOP;
                default: tx_st_q <= emi_pkg::EMI_RUN;
            endcase
        end
    end

    // ======================================================================
    // Outputs, all registered
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_q <= 1'b0;
            dma_enable_q <= 1'b1;
            err_cause_q <= 3'h0;
            rx_suspend_q <= 1'b0;
            tx_suspend_q <= 1'b0;
            tx_abort_q <= 1'b0;
        end else begin
            // Line follows latched summaries and the PHY and timestamp flags, so clearing a constituent source alone does not drop it
            irq_q <= |(src_q & en_q & ((26'h1 << `EMI_B_NORM_SUM) | (26'h1 << `EMI_B_ABN_SUM) |
                     (26'h1 << `EMI_B_PHY) | (26'h1 << `EMI_B_TSTAMP)));
            if (bus_error_ev) begin
                dma_enable_q <= 1'b0;
                err_cause_q <= bus_error_cause;
            end
            rx_suspend_q <= (rx_st_q != emi_pkg::EMI_RUN);
            tx_suspend_q <= (tx_st_q != emi_pkg::EMI_RUN);
            tx_abort_q <= jabber;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata <= `EMI_ZERO32;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= `EMI_ZERO32;
            if (rd_en) begin
                case (paddr)
                    `EMI_OFF_RAW: prdata <= {6'h00, ctrl_q[`EMI_C_MASKED_VIEW] ?
                                             (src_q & en_q) : src_q};
                    `EMI_OFF_MASKED: prdata <= {6'h00, src_q & en_q};
                    `EMI_OFF_ENABLE: prdata <= {6'h00, en_q};
                    `EMI_OFF_STATE: prdata <= {24'h000000, err_cause_q, tx_st_q, rx_st_q,
                                               dma_enable_q};
                    `EMI_OFF_CTRL: prdata <= {30'h00000000, ctrl_q};
                    default: prdata <= `EMI_ZERO32;
                endcase
            end
        end
    end

    // ======================================================================
    // Checks
    AST_IRQ_NEEDS_ENABLE: assert property (@(posedge core_clk) disable iff (!resetn)
        irq_q |-> $past(|(src_q & en_q))) else $error("irq without enabled source");
    AST_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
        (src_q[`EMI_B_RX_OVF] && !clr_mask[`EMI_B_RX_OVF]) |=> src_q[`EMI_B_RX_OVF])
        else $error("flag dropped without clear");
    AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
        (tx_underflow_ev && clr_mask[`EMI_B_TX_UNF]) |=> src_q[`EMI_B_TX_UNF])
        else $error("clear beat set");
    AST_BUS_ERR: assert property (@(posedge core_clk) disable iff (!resetn)
        bus_error_ev |=> (!dma_enable_q && src_q[`EMI_B_BUS_ERR]))
        else $error("bus error not handled");
    AST_JABBER: assert property (@(posedge core_clk) disable iff (!resetn)
        jabber |=> (src_q[`EMI_B_JABBER] && tx_abort_q && tx_st_q == emi_pkg::EMI_STOP))
        else $error("jabber not handled");
    AST_NORM_SUM: assert property (@(posedge core_clk) disable iff (!resetn)
        (src_q[`EMI_B_TX_DONE] && en_q[`EMI_B_TX_DONE]) |=> src_q[`EMI_B_NORM_SUM])
        else $error("normal summary missing");
    AST_ABN_SUM: assert property (@(posedge core_clk) disable iff (!resetn)
        (src_q[`EMI_B_BUS_ERR] && en_q[`EMI_B_BUS_ERR]) |=> src_q[`EMI_B_ABN_SUM])
        else $error("abnormal summary missing");
    AST_TS_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        (timestamp_status_read && !ts_rise) |=> !src_q[`EMI_B_TSTAMP])
        else $error("timestamp flag not cleared");
    AST_RX_RESUME: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_st_q == emi_pkg::EMI_SUSPEND && !rx_poll_demand && !rx_stop_entry)
        |=> rx_st_q == emi_pkg::EMI_SUSPEND) else $error("rx resumed without poll");

endmodule

/* bench/emi_cpu_model.sv */
// Processor interrupt controller model that counts interrupt line assertions
`timescale 1ns/1ps

module emi_cpu_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic irq_q,
    output logic [7:0] irq_cnt_q
);
    logic irq_d1_q;

    // ==========================================================
    // Edge counter
    // Counts only rising edges: a level held high is one request
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_d1_q <= 1'b0;
            irq_cnt_q <= 8'h00;
        end else begin
            irq_d1_q <= irq_q;
            if (irq_q && !irq_d1_q) begin
                irq_cnt_q <= irq_cnt_q + 8'h01;
            end
        end
    end
endmodule

/* bench/tb_top.sv */
// Self-checking testbench of the MAC interrupt block
`timescale 1ns/1ps
`include "emi_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] ev, rx_len, tx_len;
    logic [2:0] cause;
    logic rx_own, tx_own, phy, ts, irq_q, dma_en, rx_susp, tx_susp, tx_abort;
    logic [7:0] irq_cnt;
    int mismatches = 0;
    int n_tests = 0;
    int abort_cnt = 0;
    int sb[6] = '{0, 6, 14, 10, 5, 4};
    logic [13:0] lens[4] = '{14'h0800, 14'h0801, 14'h2800, 14'h2801};

    emi_irq i_emi_irq (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_done_ev(ev[0]), .rx_done_ev(ev[1]),
        .early_rx_ev(ev[2]), .early_tx_ev(ev[3]), .tx_underflow_ev(ev[4]),
        .rx_overflow_ev(ev[5]), .bus_error_ev(ev[6]), .bus_error_cause(cause),
        .rx_desc_host_owned(rx_own), .tx_desc_host_owned(tx_own),
        .rx_poll_demand(ev[9]), .tx_poll_demand(ev[10]), .rx_stop_req(ev[11]),
        .tx_stop_req(ev[12]), .rx_frame_end(ev[7]), .tx_frame_end(ev[8]),
        .rx_frame_len(rx_len), .tx_frame_len(tx_len), .phy_irq(phy), .tstamp_irq(ts),
        .timestamp_status_read(ev[13]), .irq_q(irq_q), .dma_enable_q(dma_en),
        .rx_suspend_q(rx_susp), .tx_suspend_q(tx_susp), .tx_abort_q(tx_abort)
    );

    emi_cpu_model i_emi_cpu_model (
        .core_clk(core_clk), .resetn(resetn), .irq_q(irq_q), .irq_cnt_q(irq_cnt)
    );

    always #20 core_clk = ~core_clk;

    // Abort must be a single-cycle pulse, so count its cycles
    always @(posedge core_clk) begin
        if (tx_abort === 1'b1) begin
            abort_cnt <= abort_cnt + 1;
        end
    end

    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("mismatches=%0d comparisons=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
    endtask

    // Event inputs are one-cycle pulses; four cycles cover flag, summary and line
    task automatic pulse(input int i);
        @(posedge core_clk);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        ev = 14'h0000;
        rx_len = 14'h0000;
        tx_len = 14'h0000;
        cause = 3'h0;
        rx_own = 1'b0;
        tx_own = 1'b0;
        phy = 1'b0;
        ts = 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        rdchk(`EMI_OFF_ENABLE, 32'h00000000);
        rdchk(`EMI_OFF_STATE, 32'h00000001);
        apb(1'b0, 12'h020, 32'h00000000);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        pulse(0);
        `CHK(irq_q, 1'b0)
        rdchk(`EMI_OFF_MASKED, 32'h00000000);
        wr(`EMI_OFF_ENABLE, 32'h00010001);
        // The counter in the model updates one edge after the line rises
        repeat (4) @(posedge core_clk);
        `CHK({irq_q, irq_cnt}, {1'b1, 8'h01})
        rdchk(`EMI_OFF_MASKED, 32'h00010001);
        wr(`EMI_OFF_CTRL, 32'h00000002);
        wr(`EMI_OFF_ENABLE, 32'h00010000);
        rdchk(`EMI_OFF_RAW, 32'h00010000);
        wr(`EMI_OFF_CTRL, 32'h00000000);
        // Clear and a new event land on the same edge
        fork
            wr(`EMI_OFF_CLEAR, 32'h00000001);
            begin
                repeat (2) @(posedge core_clk);
                ev[0] <= 1'b1;
                @(posedge core_clk);
                ev[0] <= 1'b0;
            end
        join
        rdchk(`EMI_OFF_RAW, 32'h00010001);
        wr(`EMI_OFF_ENABLE, 32'h00000000);
        wr(`EMI_OFF_CLEAR, 32'h03FFFFFF);
        rdchk(`EMI_OFF_RAW, 32'h00000000);
        `CHK(irq_q, 1'b0)
        for (int i = 0; i < 6; i++) begin
            wr(`EMI_OFF_ENABLE, (32'h1 << sb[i]) | 32'h00018000);
            pulse(i);
            rdchk(`EMI_OFF_RAW, (32'h1 << sb[i]) | (32'h1 << ((i < 3) ? 16 : 15)));
            `CHK({irq_q, tx_susp}, {1'b1, i == 4})
            // Underflow leaves transmit suspended until a poll demand
            if (i == 4) begin
                pulse(10);
            end
            wr(`EMI_OFF_ENABLE, 32'h00000000);
            wr(`EMI_OFF_CLEAR, 32'h03FFFFFF);
        end
        for (int j = 0; j < 4; j++) begin
            wr(`EMI_OFF_CTRL, {31'h0, j[1]});
            rx_len <= lens[j];
            pulse(7);
            rdchk(`EMI_OFF_RAW, {22'h0, j[0], 9'h0});
            wr(`EMI_OFF_CLEAR, 32'h00000200);
        end
        rx_own <= 1'b1;
        tx_own <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdchk(`EMI_OFF_RAW, 32'h00000084);
        `CHK({rx_susp, tx_susp}, 2'b11)
        rx_own <= 1'b0;
        tx_own <= 1'b0;
        pulse(9);
        pulse(10);
        `CHK({rx_susp, tx_susp}, 2'b00)
        wr(`EMI_OFF_CLEAR, 32'h03FFFFFF);
        wr(`EMI_OFF_ENABLE, 32'h01000000);
        phy <= 1'b1;
        ts <= 1'b1;
        repeat (8) @(posedge core_clk);
        rdchk(`EMI_OFF_RAW, 32'h03000000);
        `CHK(irq_q, 1'b1)
        pulse(13);
        rdchk(`EMI_OFF_RAW, 32'h01000000);
        cause <= 3'h5;
        pulse(6);
        `CHK(dma_en, 1'b0)
        rdchk(`EMI_OFF_STATE, 32'h000000B4);
        // Second reset in mid-run
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rdchk(`EMI_OFF_STATE, 32'h00000001);
        tx_len <= 14'h0801;
        pulse(8);
        apb(1'b0, `EMI_OFF_RAW, 32'h00000000);
        `CHK({rd[3], tx_susp, abort_cnt == 1}, 3'b111)
        pulse(11);
        pulse(12);
        apb(1'b0, `EMI_OFF_RAW, 32'h00000000);
        `CHK({rd[8], rd[1], rx_susp}, 3'b111)
        finish_test();
    end
endmodule
